// ---- src/adc_ctrl_top.sv ----
// register file and sequencing of the converter control block
// ****************************************
// Overview of operation
// - mode bit 6: 0 twelve-bit, 1 eight-bit
// - eight-bit result to high byte only
// - twelve-bit: high byte plus low nibble
// - division code from low bit0, mode bits1..0
// - twelve-bit time ((52/ratio)+2)/3 cycles
// - eight-bit time ((32/ratio)+2)/3 cycles
// - first twelve-bit conversion after reset or after a switch from eight-bit takes double time
// - later conversions take normal time
// - writing go bit starts a conversion
// - channel select in control bits 7..4
// - completion sets done and clears go
// - interrupt while enable and done both set
// - reset or go cleared aborts conversion
// ****************************************
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_ctrl_top
  import adc_pkg::*;
#(
  parameter logic [15:0] P_NUM_12 = `ADC_TIME_NUM_12,
  parameter logic [15:0] P_NUM_8  = `ADC_TIME_NUM_8
)
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA,
  input  wire logic [11:0] I_SAR_RESULT,
  output logic      [3:0]  O_CHANNEL,
  output logic             O_CONVERTING,
  output logic             O_RES8,
  output logic             O_DONE_IRQ,
  output logic             O_IRQ
);

  // ****************************************
  // declarations
  // ****************************************
  adc_top_state_t r;
  adc_top_state_t next_r;
  adc_setup_t     setup;
  logic [11:0]    sar_sync;
  logic           t_busy;
  logic           t_res8;
  logic           t_done;
  logic           conv_busy;
  logic           wr_ctl;
  logic           wr_mode;
  logic           wr_low;
  logic           wr_high;
  logic           wr_mask;
  logic           rd_status;
  logic           start;
  logic           abort;
  logic [7:0]     rd_val;

  // ****************************************
  // submodules
  // ****************************************
  adc_sync u_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_d     (I_SAR_RESULT),
    .o_q     (sar_sync)
  );

  adc_timer #(
    .P_NUM_12 (P_NUM_12),
    .P_NUM_8  (P_NUM_8)
  ) u_timer (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_start (start),
    .i_abort (abort),
    .i_setup (setup),
    .o_busy  (t_busy),
    .o_res8  (t_res8),
    .o_done  (t_done)
  );

  // ****************************************
  // address decode
  // ****************************************
  always_comb
  begin
    wr_ctl    = I_WR && (I_ADDR == `ADC_ADDR_CONTROL);
    wr_mode   = I_WR && (I_ADDR == `ADC_ADDR_MODE);
    wr_low    = I_WR && (I_ADDR == `ADC_ADDR_LOW);
    wr_high   = I_WR && (I_ADDR == `ADC_ADDR_HIGH);
    wr_mask   = I_WR && (I_ADDR == `ADC_ADDR_IRQ_MASK);
    rd_status = I_RD && (I_ADDR == `ADC_ADDR_IRQ_STATUS);
  end

  // ****************************************
  // conversion start and abort
  // ****************************************
  always_comb
  begin
    conv_busy      = t_busy || t_done;
    start          = wr_ctl && I_WDATA[`ADC_CTL_GO] && !conv_busy;
    abort          = wr_ctl && !I_WDATA[`ADC_CTL_GO] && t_busy;
    setup.div_code = {r.div_msb, r.div_lo};
    setup.res8     = r.res8;
    setup.dbl      = r.first12;
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    rd_val = `ADC_ZERO_BYTE;
    unique case (I_ADDR)
      `ADC_ADDR_CONTROL:
      begin
        rd_val[`ADC_CTL_CHAN_HI:`ADC_CTL_CHAN_LO] = r.channel;
        rd_val[`ADC_CTL_GO]                       = r.go;
        rd_val[`ADC_CTL_DONE]                     = r.done;
        rd_val[`ADC_CTL_IRQ_EN]                   = r.irq_en;
      end
      `ADC_ADDR_MODE:
      begin
        rd_val[`ADC_MODE_RES8]                    = r.res8;
        rd_val[`ADC_MODE_DIV_HI:`ADC_MODE_DIV_LO] = r.div_lo;
      end
      `ADC_ADDR_LOW:
      begin
        rd_val[`ADC_LOW_NIB_HI:`ADC_LOW_NIB_LO] = r.low_nib;
        rd_val[`ADC_LOW_DIV_MSB]                = r.div_msb;
      end
      `ADC_ADDR_HIGH:
      begin
        rd_val = r.high;
      end
      `ADC_ADDR_IRQ_STATUS:
      begin
        rd_val[`ADC_IRQ_DONE_BIT] = r.irq_status;
      end
      `ADC_ADDR_IRQ_MASK:
      begin
        rd_val[`ADC_IRQ_DONE_BIT] = r.irq_mask;
      end
      default:
      begin
        rd_val = `ADC_ZERO_BYTE;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_r       = r;
    next_r.rdata = I_RD ? rd_val : `ADC_ZERO_BYTE;

    // control register
    if (wr_ctl)
    begin
      next_r.channel = I_WDATA[`ADC_CTL_CHAN_HI:`ADC_CTL_CHAN_LO];
      next_r.irq_en  = I_WDATA[`ADC_CTL_IRQ_EN];
      next_r.done    = I_WDATA[`ADC_CTL_DONE];
      if (start)
      begin
        next_r.go = 1'b1;
      end
      else if (!I_WDATA[`ADC_CTL_GO])
      begin
        next_r.go = 1'b0;
      end
    end

    // mode register, reserved bits held at zero
    if (wr_mode)
    begin
      next_r.res8   = I_WDATA[`ADC_MODE_RES8];
      next_r.div_lo = I_WDATA[`ADC_MODE_DIV_HI:`ADC_MODE_DIV_LO];
      if (r.res8 && !I_WDATA[`ADC_MODE_RES8])
      begin
        next_r.first12 = 1'b1;
      end
    end

    // result low byte and timing bit
    if (wr_low)
    begin
      next_r.low_nib = I_WDATA[`ADC_LOW_NIB_HI:`ADC_LOW_NIB_LO];
      next_r.div_msb = I_WDATA[`ADC_LOW_DIV_MSB];
    end

    if (wr_high)
    begin
      next_r.high = I_WDATA;
    end

    if (wr_mask)
    begin
      next_r.irq_mask = I_WDATA[`ADC_IRQ_DONE_BIT];
    end

    // status clears on read
    if (rd_status)
    begin
      next_r.irq_status = 1'b0;
    end

    // completion wins over software writes, except that a mode switch to twelve-bit keeps first12 set
    if (t_done)
    begin
      next_r.done       = 1'b1;
      next_r.go         = 1'b0;
      next_r.irq_status = 1'b1;
      next_r.high       = sar_sync[11:4];
      if (!t_res8)
      begin
        next_r.low_nib = sar_sync[3:0];
        if (!(wr_mode && r.res8 && !I_WDATA[`ADC_MODE_RES8]))
        begin
          next_r.first12 = 1'b0;
        end
      end
    end

    // registered interrupt lines
    next_r.done_irq = next_r.done && next_r.irq_en;
    next_r.irq      = next_r.irq_status && next_r.irq_mask;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      r         <= '0;
      r.first12 <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign O_RDATA      = r.rdata;
  assign O_CHANNEL    = r.channel;
  assign O_CONVERTING = r.go;
  assign O_RES8       = r.res8;
  assign O_DONE_IRQ   = r.done_irq;
  assign O_IRQ        = r.irq;

endmodule

// ---- shared/adc_consts.svh ----
// constants of the converter control block
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ****************************************
// register addresses
// ****************************************
`define ADC_ADDR_CONTROL     16'hFE58
`define ADC_ADDR_MODE        16'hFE59
`define ADC_ADDR_LOW         16'hFE5A
`define ADC_ADDR_HIGH        16'hFE5B
`define ADC_ADDR_IRQ_STATUS  16'hFE5C
`define ADC_ADDR_IRQ_MASK    16'hFE5D

// ****************************************
// field positions
// ****************************************
`define ADC_CTL_CHAN_HI      7
`define ADC_CTL_CHAN_LO      4
`define ADC_CTL_GO           2
`define ADC_CTL_DONE         1
`define ADC_CTL_IRQ_EN       0
`define ADC_MODE_RES8        6
`define ADC_MODE_DIV_HI      1
`define ADC_MODE_DIV_LO      0
`define ADC_LOW_NIB_HI       7
`define ADC_LOW_NIB_LO       4
`define ADC_LOW_DIV_MSB      0
`define ADC_IRQ_DONE_BIT     0

// ****************************************
// reset values and timing
// ****************************************
`define ADC_RESET_BYTE       8'h00
`define ADC_ZERO_BYTE        8'h00
`define ADC_TIME_NUM_12      52
`define ADC_TIME_NUM_8       32
`define ADC_TIME_ADD         16'h0002
`define ADC_TIME_DIV         16'h0003
`define ADC_CNT_ONE          16'h0001
`define ADC_CNT_ZERO         16'h0000

`endif

// ---- shared/adc_pkg.sv ----
// types of the converter control block
package adc_pkg;

  // ****************************************
  // timer states
  // ****************************************
  typedef enum logic [0:0] {
    ADC_T_IDLE,
    ADC_T_RUN
  } adc_tstate_t;

  // ****************************************
  // timer settings and state
  // ****************************************
  typedef struct packed {
    logic [2:0] div_code;
    logic       res8;
    logic       dbl;
  } adc_setup_t;

  typedef struct packed {
    adc_tstate_t st;
    logic [15:0] cnt;
    logic        res8;
    logic        done;
  } adc_timer_state_t;

  typedef struct packed {
    logic [11:0] meta;
    logic [11:0] q;
  } adc_sync_state_t;

  // ****************************************
  // top state
  // ****************************************
  typedef struct packed {
    logic [3:0] channel;
    logic       go;
    logic       done;
    logic       irq_en;
    logic       res8;
    logic [1:0] div_lo;
    logic [3:0] low_nib;
    logic       div_msb;
    logic [7:0] high;
    logic       first12;
    logic       irq_status;
    logic       irq_mask;
    logic [7:0] rdata;
    logic       done_irq;
    logic       irq;
  } adc_top_state_t;

endpackage

// ---- src/adc_sync.sv ----
// two-stage synchroniser for the comparator result word
`timescale 1ns/1ps
module adc_sync
  import adc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [11:0] i_d,
  output logic      [11:0] o_q
);

  adc_sync_state_t r;
  adc_sync_state_t next_r;

  always_comb
  begin
    next_r      = r;
    next_r.meta = i_d;
    next_r.q    = r.meta;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_q = r.q;

endmodule

// ---- src/adc_timer.sv ----
// conversion time counter
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_timer
  import adc_pkg::*;
#(
  parameter logic [15:0] P_NUM_12 = `ADC_TIME_NUM_12,
  parameter logic [15:0] P_NUM_8  = `ADC_TIME_NUM_8
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic       i_abort,
  input  adc_setup_t      i_setup,
  output logic            o_busy,
  output logic            o_res8,
  output logic            o_done
);

  adc_timer_state_t r;
  adc_timer_state_t next_r;
  logic [15:0]      base;
  logic [15:0]      cycles;

  // ((num / ratio) + 2) / 3 cycles, rounded up, doubled on request in twelve-bit mode only
  always_comb
  begin
    base   = ((i_setup.res8 ? P_NUM_8 : P_NUM_12) << i_setup.div_code) + `ADC_TIME_ADD;
    cycles = (base + `ADC_TIME_DIV - `ADC_CNT_ONE) / `ADC_TIME_DIV;
    if (i_setup.dbl && !i_setup.res8)
    begin
      cycles = {cycles[14:0], 1'b0};
    end
  end

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    unique case (r.st)
      ADC_T_IDLE:
      begin
        if (i_start)
        begin
          next_r.st   = ADC_T_RUN;
          next_r.cnt  = cycles;
          next_r.res8 = i_setup.res8;
        end
      end
      ADC_T_RUN:
      begin
        if (i_abort)
        begin
          next_r.st  = ADC_T_IDLE;
          next_r.cnt = `ADC_CNT_ZERO;
        end
        else if (r.cnt == `ADC_CNT_ONE)
        begin
          next_r.st   = ADC_T_IDLE;
          next_r.cnt  = `ADC_CNT_ZERO;
          next_r.done = 1'b1;
        end
        else
        begin
          next_r.cnt = r.cnt - `ADC_CNT_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      r <= '{st: ADC_T_IDLE, cnt: '0, res8: 1'b0, done: 1'b0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_busy = (r.st == ADC_T_RUN);
  assign o_res8 = r.res8;
  assign o_done = r.done;

endmodule

// ---- dv/adc_ctrl_checker.sv ----
// port assertions of the converter control block
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_ctrl_checker
#(
  parameter logic [15:0] P_NUM_12 = `ADC_TIME_NUM_12,
  parameter logic [15:0] P_NUM_8  = `ADC_TIME_NUM_8
)
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [7:0]  O_RDATA,
  input  wire logic [3:0]  O_CHANNEL,
  input  wire logic        O_CONVERTING,
  input  wire logic        O_RES8,
  input  wire logic        O_DONE_IRQ,
  input  wire logic        O_IRQ
);
  // ****************************************
  // helpers and assertions
  // ****************************************
  localparam int C_RUN_MAX = 2 * ((int'(P_NUM_12 + P_NUM_8) * 128 + 4) / 3) + 3;
  logic [15:0] run_cnt;
  wire         wr_ctl = I_WR && I_ADDR == `ADC_ADDR_CONTROL;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  // cycles spent converting
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N || !O_CONVERTING)
      run_cnt <= 16'h0000;
    else
      run_cnt <= run_cnt + 16'h0001;
  end

  AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data not zero outside answer cycle");
  AST_GO_START: assert property (wr_ctl && I_WDATA[2] && !O_CONVERTING |=> O_CONVERTING)
    else $error("start write did not start");
  AST_GO_ABORT: assert property (wr_ctl && !I_WDATA[2] && O_CONVERTING |=> !O_CONVERTING)
    else $error("go clear did not abort");
  AST_CHAN: assert property (wr_ctl |=> O_CHANNEL == $past(I_WDATA[7:4]))
    else $error("channel field not taken");
  AST_RES8: assert property (I_WR && I_ADDR == `ADC_ADDR_MODE |=> O_RES8 == $past(I_WDATA[6]))
    else $error("resolution bit not taken");
  AST_DONE_IRQ_OFF: assert property (wr_ctl && !(I_WDATA[1] && I_WDATA[0]) && !O_CONVERTING |=> !O_DONE_IRQ)
    else $error("done request stayed up");
  AST_RUN_MAX: assert property (run_cnt < C_RUN_MAX)
    else $error("conversion ran too long");
  AST_IRQ_CLR: assert property (I_RD && I_ADDR == `ADC_ADDR_IRQ_STATUS && !O_CONVERTING |-> ##2 !O_IRQ)
    else $error("status read left interrupt up");
endmodule

// ---- dv/adc_mode_timing_results_bench.sv ----
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "adc_consts.svh"
module adc_mode_timing_results_bench;
  // ****************************************
  // signals, drivers and checks
  // ****************************************
  localparam logic [15:0] C_N12 = 16'h0004;
  localparam logic [15:0] C_N8  = 16'h0002;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr  = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [11:0] sar   = 12'h000;
  logic [7:0]  rdata;
  logic [3:0]  chan;
  logic        conv;
  logic        res8;
  logic        done_irq;
  logic        irq;
  logic [7:0]  v;
  int          cnt;
  int          cyc        = 0;
  int          num_errors = 0;
  int          n_tests    = 0;

  adc_ctrl_top #(.P_NUM_12(C_N12), .P_NUM_8(C_N8)) adc_ctrl_top_inst
  (
    .I_CORE_CLK   (clk),
    .I_RST_N      (rst_n),
    .I_ADDR       (addr),
    .I_WDATA      (wdata),
    .I_WR         (wr),
    .I_RD         (rd),
    .O_RDATA      (rdata),
    .I_SAR_RESULT (sar),
    .O_CHANNEL    (chan),
    .O_CONVERTING (conv),
    .O_RES8       (res8),
    .O_DONE_IRQ   (done_irq),
    .O_IRQ        (irq)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // go stands one cycle past the count while done registers
  function automatic int exp_n(int num, int code, bit dbl);
    return (dbl ? 2 : 1) * (((num << code) + 4) / 3) + 1;
  endfunction

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [15:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // start and count converting cycles
  task automatic run(input logic [7:0] ctl);
    bus_wr(`ADC_ADDR_CONTROL, ctl);
    cnt = 0;
    @(negedge clk);
    while (conv && cnt < 2000)
    begin
      cnt++;
      @(negedge clk);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    for (int a = 16'hFE58; a <= 16'hFE5E; a++)
    begin
      bus_rd(a[15:0]);
      check(v, 8'h00);
    end
    check({conv, res8, done_irq, irq}, 4'h0);
    $display("reset test ended");
  endtask

  task automatic t_twelve();
    sar <= 12'hABC;
    run(8'h55);
    check(cnt, exp_n(C_N12, 0, 1));
    check(chan, 4'h5);
    check(done_irq, 1'b1);
    bus_rd(`ADC_ADDR_CONTROL);
    check(v, 8'h53);
    bus_rd(`ADC_ADDR_HIGH);
    check(v, 8'hAB);
    bus_rd(`ADC_ADDR_LOW);
    check(v, 8'hC0);
    bus_wr(`ADC_ADDR_CONTROL, 8'h51);
    @(negedge clk);
    check(done_irq, 1'b0);
    bus_wr(`ADC_ADDR_LOW, 8'h01);
    bus_wr(`ADC_ADDR_MODE, 8'h01);
    sar <= 12'h123;
    run(8'h55);
    check(cnt, exp_n(C_N12, 5, 0));
    bus_rd(`ADC_ADDR_HIGH);
    check(v, 8'h12);
    bus_rd(`ADC_ADDR_LOW);
    check(v, 8'h31);
    $display("twelve-bit test ended");
  endtask

  task automatic t_eight();
    for (int c = 0; c < 8; c++)
    begin
      bus_wr(`ADC_ADDR_LOW, {4'h5, 3'h0, c[2]});
      bus_wr(`ADC_ADDR_MODE, {6'h10, c[1:0]});
      sar <= {8'h30 + c[7:0], 4'h9};
      run(8'h55);
      check(cnt, exp_n(C_N8, c, 0));
      check(res8, 1'b1);
      bus_rd(`ADC_ADDR_HIGH);
      check(v, 8'h30 + c[7:0]);
      bus_rd(`ADC_ADDR_LOW);
      check(v, {4'h5, 3'h0, c[2]});
    end
    $display("eight-bit test ended");
  endtask

  task automatic t_switch();
    bus_wr(`ADC_ADDR_LOW, 8'h00);
    bus_wr(`ADC_ADDR_MODE, 8'h00);
    @(negedge clk);
    check(res8, 1'b0);
    run(8'h55);
    check(cnt, exp_n(C_N12, 0, 1));
    run(8'h55);
    check(cnt, exp_n(C_N12, 0, 0));
    $display("mode switch test ended");
  endtask

  task automatic t_abort();
    bus_wr(`ADC_ADDR_LOW, 8'h01);
    bus_wr(`ADC_ADDR_MODE, 8'h03);
    sar <= 12'hFFF;
    bus_wr(`ADC_ADDR_CONTROL, 8'h55);
    repeat (5) @(posedge clk);
    bus_wr(`ADC_ADDR_CONTROL, 8'h51);
    @(negedge clk);
    check(conv, 1'b0);
    repeat (200) @(posedge clk);
    bus_rd(`ADC_ADDR_CONTROL);
    check(v, 8'h51);
    bus_rd(`ADC_ADDR_HIGH);
    check(v, 8'h37);
    $display("abort test ended");
  endtask

  task automatic t_irq();
    bus_wr(`ADC_ADDR_LOW, 8'h00);
    bus_wr(`ADC_ADDR_MODE, 8'h00);
    bus_rd(`ADC_ADDR_IRQ_STATUS);
    bus_rd(`ADC_ADDR_IRQ_STATUS);
    check(v, 8'h00);
    bus_wr(`ADC_ADDR_IRQ_MASK, 8'h01);
    run(8'h55);
    check(irq, 1'b1);
    bus_rd(`ADC_ADDR_IRQ_STATUS);
    check(v, 8'h01);
    check(irq, 1'b0);
    bus_wr(`ADC_ADDR_IRQ_MASK, 8'h00);
    run(8'h55);
    check(irq, 1'b0);
    bus_rd(`ADC_ADDR_IRQ_STATUS);
    check(v, 8'h01);
    $display("interrupt test ended");
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_twelve();
    t_eight();
    t_switch();
    t_abort();
    t_irq();
    print_verdict();
  end
endmodule

bind adc_ctrl_top adc_ctrl_checker #(.P_NUM_12(P_NUM_12), .P_NUM_8(P_NUM_8)) adc_ctrl_checker_inst
(
  .I_CORE_CLK   (I_CORE_CLK),
  .I_RST_N      (I_RST_N),
  .I_ADDR       (I_ADDR),
  .I_WDATA      (I_WDATA),
  .I_WR         (I_WR),
  .I_RD         (I_RD),
  .O_RDATA      (O_RDATA),
  .O_CHANNEL    (O_CHANNEL),
  .O_CONVERTING (O_CONVERTING),
  .O_RES8       (O_RES8),
  .O_DONE_IRQ   (O_DONE_IRQ),
  .O_IRQ        (O_IRQ)
);
